// >>> tpc_computer_model.sv
`timescale 1ns/1ps
module tpc_computer_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bench request
  input wire logic go,
  input wire logic [5:0] wdata,
  // block side
  input wire logic busy_level,
  output logic buffer_clear_pulse,
  output logic data_out_pulse,
  output logic [5:0] data_in
);
  logic [1:0] step_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      step_q <= 2'h0;
      buffer_clear_pulse <= 1'b0;
      data_out_pulse <= 1'b0;
      data_in <= 6'h2A;
    end else begin
      buffer_clear_pulse <= step_q == 2'h0 && go && !busy_level;
      data_out_pulse <= step_q == 2'h1;
      // outside the load cycle the data lines toggle so a stale sample shows
      data_in <= (step_q == 2'h1) ? wdata : ~data_in;
      if (step_q == 2'h0) begin
        step_q <= (go && !busy_level) ? 2'h1 : 2'h0;
      end else begin
        step_q <= (step_q == 2'h1) ? 2'h2 : 2'h0;
      end
    end
  end
endmodule // tpc_computer_model

// >>> tpc_perforator_ctrl.sv
`timescale 1ns/1ps

module tpc_fifo #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // count is one bit wider than the pointers so full and empty differ
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } tpc_fifo_state_t;

  tpc_fifo_state_t q;
  tpc_fifo_state_t d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      ptr_next = '0;
    end else begin
      ptr_next = p + AW'(1);
    end
  endfunction

  assign in_ready = (q.count != FULL_CNT);
  assign out_valid = (q.count != '0);
  assign out_data = q.mem[q.rd_ptr];

  always_comb begin
    d = q;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = ptr_next(q.wr_ptr);
    end
    if (pop) begin
      d.rd_ptr = ptr_next(q.rd_ptr);
    end
    case ({push, pop})
      2'b10: d.count = q.count + (AW+1)'(1);
      2'b01: d.count = q.count - (AW+1)'(1);
      default: d.count = q.count;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // tpc_fifo

module tpc_perforator_ctrl #(
  parameter longint unsigned SPINUP_CYCLES = tpc_pkg::SPINUP_CYC,
  parameter longint unsigned HOLD_CYCLES = tpc_pkg::HOLD_CYC,
  parameter longint unsigned LUBE_LIMIT_CYCLES = tpc_pkg::LUBE_LIMIT_CYC,
  parameter longint unsigned LUBE_ADVISE_CYCLES = tpc_pkg::LUBE_ADVISE_CYC,
  parameter int unsigned FIFO_DEPTH = tpc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // computer side, same clock
  input wire logic buffer_clear_pulse,
  input wire logic data_out_pulse,
  input wire logic [tpc_pkg::DATA_W-1:0] data_in,
  input wire logic seventh_hole_mode,
  input wire logic connect_pulse,
  output logic busy_level,
  output logic raise_flag_pulse,
  output logic alarm_error_flag,
  output logic xfer_ready,
  // mechanism sync pickups, asynchronous
  input wire logic start_punch_sync,
  input wire logic end_punch_sync,
  input wire logic end_feed_sync,
  // panel switches and sensors, asynchronous
  input wire logic manual_feed_sw,
  input wire logic alarm_switch,
  input wire logic tape_low_level,
  input wire logic supply_fail,
  input wire logic end_of_tape,
  input wire logic lube_reset_sw,
  // mechanism drive
  output logic motor_run,
  output logic hole_drive,
  output logic [tpc_pkg::LINE_W-1:0] punch_data,
  output logic tape_advance,
  // operator indication
  output logic alarm_lamp,
  output logic alarm_buzzer,
  output logic lube_due
);

  localparam int unsigned LW = tpc_pkg::LINE_W;
  localparam tpc_pkg::tpc_timer_t SPINUP_LOAD = tpc_pkg::tpc_timer_t'(SPINUP_CYCLES);
  localparam tpc_pkg::tpc_timer_t HOLD_LOAD = tpc_pkg::tpc_timer_t'(HOLD_CYCLES);
  localparam tpc_pkg::tpc_lube_t LUBE_LIMIT = tpc_pkg::tpc_lube_t'(LUBE_LIMIT_CYCLES);
  localparam tpc_pkg::tpc_lube_t LUBE_ADVISE = tpc_pkg::tpc_lube_t'(LUBE_ADVISE_CYCLES);
  // local copy of the queue fill, wide enough to hold the full count
  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] LINES_FULL = CW'(FIFO_DEPTH);

  typedef struct packed {
    // [0] first stage, [1] second stage, [2] edge history
    logic [2:0] sp_sync;
    logic [2:0] ep_sync;
    logic [2:0] ef_sync;
    logic [1:0] feed_sw_sync;
    logic [1:0] alarm_sw_sync;
    logic [1:0] tape_low_sync;
    logic [1:0] supply_sync;
    logic [1:0] eot_sync;
    logic [1:0] lube_rst_sync;
    logic [LW-1:0] load_word;
    logic push_pend;
    logic buffer_free;
    logic busy;
    logic cycle_pending;
    logic hole_drive;
    logic tape_advance;
    logic [LW-1:0] hole_word;
    logic [LW-1:0] punch_data;
    tpc_pkg::tpc_motor_t motor;
    tpc_pkg::tpc_timer_t hold_cnt;
    tpc_pkg::tpc_timer_t spin_cnt;
    tpc_pkg::tpc_lube_t lube_cnt;
    logic motor_run;
    logic raise_flag;
    logic alarm_latched;
    logic alarm_error;
    logic alarm_lamp;
    logic alarm_buzzer;
    logic lube_due;
    logic xfer_ready;
    logic [CW-1:0] lines;
  } tpc_state_t;

  // buffer starts free so the first transfer is not held off
  localparam tpc_state_t RESET_STATE = '{
    buffer_free: tpc_pkg::RST_BUFFER_FREE,
    busy: ~tpc_pkg::RST_BUFFER_FREE,
    motor: tpc_pkg::TPC_MOTOR_OFF,
    default: '0
  };

  tpc_state_t q;
  tpc_state_t d;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [LW-1:0] fifo_out_data;
  logic fifo_pop;

  // rising edge seen between the second stage and the history flop
  function automatic logic sync_rise(input logic [2:0] s);
    sync_rise = s[1] & ~s[2];
  endfunction

  logic sp_ev;
  logic ep_ev;
  logic ef_ev;
  logic at_speed;
  logic blocked;
  logic shutdown;
  logic alarm_cause;
  logic retrigger;
  logic hole_set;
  logic hole_fall;
  logic feed_sw;

  tpc_fifo #(
    .WIDTH(LW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(q.push_pend),
    .in_ready(fifo_in_ready),
    .in_data(q.load_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always_comb begin
    d = q;

    // pins enter through two flops; logic reads stage [1] and, for edges, the history bit [2]
    d.sp_sync = {q.sp_sync[1:0], start_punch_sync};
    d.ep_sync = {q.ep_sync[1:0], end_punch_sync};
    d.ef_sync = {q.ef_sync[1:0], end_feed_sync};
    d.feed_sw_sync = {q.feed_sw_sync[0], manual_feed_sw};
    d.alarm_sw_sync = {q.alarm_sw_sync[0], alarm_switch};
    d.tape_low_sync = {q.tape_low_sync[0], tape_low_level};
    d.supply_sync = {q.supply_sync[0], supply_fail};
    d.eot_sync = {q.eot_sync[0], end_of_tape};
    d.lube_rst_sync = {q.lube_rst_sync[0], lube_reset_sw};

    sp_ev = sync_rise(q.sp_sync);
    ep_ev = sync_rise(q.ep_sync);
    ef_ev = sync_rise(q.ef_sync);
    feed_sw = q.feed_sw_sync[1];
    at_speed = (q.motor == tpc_pkg::TPC_MOTOR_RATED);

    // tape low only warns; supply or tape-end failures block the punch
    blocked = q.supply_sync[1] | q.eot_sync[1];
    shutdown = (q.lube_cnt >= LUBE_LIMIT);
    alarm_cause = q.tape_low_sync[1] | blocked | shutdown;

    // staging word: clear pulse empties it, data-out ORs the line in
    if (buffer_clear_pulse) begin
      d.load_word = '0;
    end
    if (data_out_pulse) begin
      d.load_word = (buffer_clear_pulse ? '0 : q.load_word)
                    | {seventh_hole_mode, data_in};
      d.push_pend = 1'h1;
    end else if (q.push_pend && fifo_in_ready) begin
      d.push_pend = 1'h0;
    end

    // variable delay: each transfer or feed end restarts it
    // a held feed switch keeps retriggering, so the motor stops under it only on lubrication shutdown
    retrigger = data_out_pulse | ef_ev | feed_sw;
    // an expired lubrication timer overrides every restart source
    if (shutdown) begin
      d.hold_cnt = '0;
    end else if (retrigger) begin
      d.hold_cnt = HOLD_LOAD;
    end else if (q.hold_cnt != '0) begin
      d.hold_cnt = q.hold_cnt - tpc_pkg::tpc_timer_t'(1);
    end
    d.motor_run = (d.hold_cnt != '0);

    // spin-up delay before syncs count
    case (q.motor)
      tpc_pkg::TPC_MOTOR_OFF: begin
        d.spin_cnt = SPINUP_LOAD;
        if (q.motor_run) begin
          d.motor = tpc_pkg::TPC_MOTOR_SPINUP;
        end
      end
      tpc_pkg::TPC_MOTOR_SPINUP: begin
        if (!q.motor_run) begin
          d.motor = tpc_pkg::TPC_MOTOR_OFF;
        end else if (q.spin_cnt <= tpc_pkg::tpc_timer_t'(1)) begin
          d.motor = tpc_pkg::TPC_MOTOR_RATED;
        end else begin
          d.spin_cnt = q.spin_cnt - tpc_pkg::tpc_timer_t'(1);
        end
      end
      tpc_pkg::TPC_MOTOR_RATED: begin
        if (!q.motor_run) begin
          d.motor = tpc_pkg::TPC_MOTOR_OFF;
        end
      end
      default: begin
        d.motor = tpc_pkg::TPC_MOTOR_OFF;
      end
    endcase

    // hole drive: start-punch with a pending line, not blocked
    hole_set = sp_ev & at_speed & q.cycle_pending & ~q.hole_drive & ~q.tape_advance
               & fifo_out_valid & ~blocked;
    hole_fall = ep_ev & at_speed & q.hole_drive;
    fifo_pop = hole_set;
    if (hole_set) begin
      d.hole_drive = 1'h1;
      d.hole_word = fifo_out_data;
    end else if (hole_fall) begin
      d.hole_drive = 1'h0;
    end

    // fill mirror: ready must fall in the cycle the last slot fills, not one later
    if (q.push_pend && fifo_in_ready && !fifo_pop) begin
      d.lines = q.lines + CW'(1);
    end else if (fifo_pop && !(q.push_pend && fifo_in_ready)) begin
      d.lines = q.lines - CW'(1);
    end
    d.xfer_ready = (d.lines != LINES_FULL) & ~d.push_pend;

    // pending: a new transfer wins over the clear from the falling hole drive
    if (data_out_pulse) begin
      d.cycle_pending = 1'h1;
    end else if (hole_fall) begin
      // a line still being staged into the queue keeps the cycle pending
      d.cycle_pending = fifo_out_valid | q.push_pend;
    end

    // the end-punch pulse doubles as start of feed
    if (ep_ev && at_speed && (q.hole_drive || (feed_sw && !blocked))) begin
      d.tape_advance = 1'h1;
    end else if (ef_ev && at_speed) begin
      d.tape_advance = 1'h0;
    end

    d.punch_data = d.hole_drive ? d.hole_word : '0;

    // buffer-free: the set from the synced end-punch wins over data-out
    if (ep_ev && at_speed) begin
      d.buffer_free = 1'h1;
    end else if (data_out_pulse) begin
      d.buffer_free = 1'h0;
    end
    d.busy = ~d.buffer_free;
    d.raise_flag = ep_ev & at_speed;

    // lubrication hours count only while the motor turns
    if (q.lube_rst_sync[1]) begin
      d.lube_cnt = '0;
    end else if (q.motor_run && !shutdown) begin
      d.lube_cnt = q.lube_cnt + tpc_pkg::tpc_lube_t'(1);
    end
    d.lube_due = (d.lube_cnt >= LUBE_ADVISE);

    // alarm latch survives acknowledge; only reset with cause gone frees it
    d.alarm_latched = alarm_cause
                      | (q.alarm_latched & (q.alarm_sw_sync[1] == tpc_pkg::ALARM_SW_ACK));
    d.alarm_lamp = d.alarm_latched;
    d.alarm_buzzer = d.alarm_latched
                     & (q.alarm_sw_sync[1] != tpc_pkg::ALARM_SW_ACK);

    // error flag: set at the next transfer, cleared only by connect
    if (data_out_pulse && q.alarm_latched) begin
      d.alarm_error = 1'h1;
    end else if (connect_pulse) begin
      d.alarm_error = 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign busy_level = q.busy;
  assign raise_flag_pulse = q.raise_flag;
  assign alarm_error_flag = q.alarm_error;
  assign xfer_ready = q.xfer_ready;
  assign motor_run = q.motor_run;
  assign hole_drive = q.hole_drive;
  assign punch_data = q.punch_data;
  assign tape_advance = q.tape_advance;
  assign alarm_lamp = q.alarm_lamp;
  assign alarm_buzzer = q.alarm_buzzer;
  assign lube_due = q.lube_due;

endmodule // tpc_perforator_ctrl

// >>> tpc_perforator_ctrl_bench.sv
`timescale 1ns/1ps
module tpc_perforator_ctrl_bench;
  logic mclk = 0;
  logic resetn = 0;
  logic go = 0;
  logic [5:0] wdata = 6'h00;
  logic buffer_clear_pulse, data_out_pulse;
  logic [5:0] data_in;
  logic seventh_hole_mode = 0, connect_pulse = 0, manual_feed_sw = 0, alarm_switch = 0;
  logic tape_low_level = 0, supply_fail = 0, end_of_tape = 0, lube_reset_sw = 0;
  logic [2:0] sync_pins = 3'h0;
  logic busy_level, raise_flag_pulse, alarm_error_flag, xfer_ready, motor_run, hole_drive;
  logic tape_advance, alarm_lamp, alarm_buzzer, lube_due;
  logic [6:0] punch_data;
  int mismatches = 0, samples_checked = 0, cycles = 0, raise_cnt = 0, r0;
  logic [5:0] d;
  logic m;

  tpc_perforator_ctrl #(.SPINUP_CYCLES(20), .HOLD_CYCLES(100), .LUBE_LIMIT_CYCLES(2000),
    .LUBE_ADVISE_CYCLES(1500)) tpc_perforator_ctrl_inst (.mclk(mclk), .resetn(resetn),
    .buffer_clear_pulse(buffer_clear_pulse), .data_out_pulse(data_out_pulse), .data_in(data_in),
    .seventh_hole_mode(seventh_hole_mode), .connect_pulse(connect_pulse),
    .busy_level(busy_level), .raise_flag_pulse(raise_flag_pulse),
    .alarm_error_flag(alarm_error_flag), .xfer_ready(xfer_ready),
    .start_punch_sync(sync_pins[0]), .end_punch_sync(sync_pins[1]),
    .end_feed_sync(sync_pins[2]), .manual_feed_sw(manual_feed_sw), .alarm_switch(alarm_switch),
    .tape_low_level(tape_low_level), .supply_fail(supply_fail), .end_of_tape(end_of_tape),
    .lube_reset_sw(lube_reset_sw), .motor_run(motor_run), .hole_drive(hole_drive),
    .punch_data(punch_data), .tape_advance(tape_advance), .alarm_lamp(alarm_lamp),
    .alarm_buzzer(alarm_buzzer), .lube_due(lube_due));
  tpc_computer_model tpc_computer_model_inst (.mclk(mclk), .resetn(resetn), .go(go),
    .wdata(wdata), .busy_level(busy_level), .buffer_clear_pulse(buffer_clear_pulse),
    .data_out_pulse(data_out_pulse), .data_in(data_in));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [6:0] line_of(logic mode, logic [5:0] bits);
    return {mode, bits};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [6:0] exp, logic [6:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask

  // outputs are read half a cycle after the edge so every register has landed
  task automatic look();
    @(negedge mclk);
  endtask

  task automatic rst();
    tick(1);
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(1);
    look();
  endtask

  task automatic xfer(logic [5:0] bits, logic mode);
    tick(1);
    wdata <= bits;
    seventh_hole_mode <= mode;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
    look();
    chk("busy_level", 7'h1, busy_level);
    chk("motor_run", 7'h1, motor_run);
    chk("xfer_ready load", 7'h0, xfer_ready);
    look();
    chk("xfer_ready", 7'h1, xfer_ready);
  endtask

  // pin held 4 cycles each way, well past the synchronizer's needs
  task automatic sync(int i);
    tick(1);
    sync_pins[i] <= 1'b1;
    tick(4);
    sync_pins[i] <= 1'b0;
    tick(4);
    look();
  endtask

  always @(posedge mclk) begin
    if (raise_flag_pulse === 1'b1) raise_cnt <= raise_cnt + 1;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'h27E2));
    rst();
    chk("reset outs", 7'h0, {busy_level, motor_run, hole_drive, tape_advance,
      alarm_lamp, alarm_error_flag, lube_due});
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($urandom);
      m = (i < 2) ? i[0] : 1'($urandom);
      xfer(d, m);
      if (i == 0) begin
        sync(0);
        chk("hole before speed", 7'h0, hole_drive);
        tick(20);
      end
      sync(0);
      chk("hole_drive", 7'h1, hole_drive);
      chk("punch_data", line_of(m, d), punch_data);
      r0 = raise_cnt;
      sync(1);
      chk("hole_drive off", 7'h0, hole_drive);
      chk("tape_advance", 7'h1, tape_advance);
      chk("busy_level off", 7'h0, busy_level);
      chk("raise count", 7'(r0 + 1), 7'(raise_cnt));
      sync(2);
      chk("advance off", 7'h0, tape_advance);
    end
    sync(0);
    chk("hole no pending", 7'h0, hole_drive);
    tick(110);
    look();
    chk("motor stopped", 7'h0, motor_run);
    $display("test punch cycles done");
    rst();
    tick(1);
    manual_feed_sw <= 1'b1;
    tick(30);
    sync(1);
    chk("manual motor", 7'h1, motor_run);
    chk("manual advance", 7'h1, tape_advance);
    sync(2);
    tick(2100);
    look();
    chk("lube shutdown", 7'h3, {lube_due, alarm_lamp});
    chk("lube motor", 7'h0, motor_run);
    tick(1);
    manual_feed_sw <= 1'b0;
    lube_reset_sw <= 1'b1;
    tick(4);
    lube_reset_sw <= 1'b0;
    look();
    chk("lube cleared", 7'h0, lube_due);
    $display("test manual and lube done");
    rst();
    tick(1);
    tape_low_level <= 1'b1;
    tick(6);
    look();
    chk("low alarm", 7'h3, {alarm_lamp, alarm_buzzer});
    xfer(6'h2D, 1'b0);
    chk("error flag", 7'h1, alarm_error_flag);
    tick(25);
    sync(0);
    chk("low still punches", 7'h1, hole_drive);
    tick(1);
    alarm_switch <= 1'b1;
    tape_low_level <= 1'b0;
    tick(6);
    look();
    chk("ack state", 7'h5, {alarm_lamp, alarm_buzzer, alarm_error_flag});
    tick(1);
    alarm_switch <= 1'b0;
    tick(6);
    look();
    chk("reset state", 7'h1, {alarm_lamp, alarm_buzzer, alarm_error_flag});
    tick(1);
    connect_pulse <= 1'b1;
    tick(1);
    connect_pulse <= 1'b0;
    tick(2);
    look();
    chk("connect clears", 7'h0, alarm_error_flag);
    $display("test alarms done");
    for (int k = 0; k < 2; k++) begin
      rst();
      tick(1);
      supply_fail <= (k == 0);
      end_of_tape <= (k == 1);
      xfer(6'h15, 1'b1);
      tick(25);
      sync(0);
      chk("blocked hole", 7'h0, hole_drive);
      chk("blocked lamp", 7'h1, alarm_lamp);
      tick(110);
      look();
      chk("blocked motor", 7'h0, motor_run);
    end
    $display("test blocked supply done");
    summarize();
  end
endmodule // tpc_perforator_ctrl_bench

// >>> tpc_perforator_ctrl_monitor.sv
`timescale 1ns/1ps
module tpc_perforator_ctrl_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // computer side
  input wire logic data_out_pulse,
  input wire logic connect_pulse,
  input wire logic busy_level,
  input wire logic raise_flag_pulse,
  input wire logic alarm_error_flag,
  // mechanism and panel
  input wire logic motor_run,
  input wire logic hole_drive,
  input wire logic [tpc_pkg::LINE_W-1:0] punch_data,
  input wire logic tape_advance,
  input wire logic alarm_lamp,
  input wire logic alarm_buzzer,
  input wire logic lube_due
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a synced end-punch landing with the load wins, so that cycle is excused
  busy_on_load_a: assert property (data_out_pulse ##1 !raise_flag_pulse |-> busy_level)
    else $error("busy not raised after load");
  // an expiring lubrication timer may hold the motor off; it is flagged well ahead
  motor_on_load_a: assert property (data_out_pulse && !lube_due |=> motor_run)
    else $error("motor not running after load");
  raise_frees_a: assert property (raise_flag_pulse |-> !busy_level)
    else $error("busy still set with raise flag");
  busy_fall_a: assert property ($fell(busy_level) |-> raise_flag_pulse)
    else $error("busy fell without raise flag");
  raise_single_a: assert property (raise_flag_pulse |=> !raise_flag_pulse)
    else $error("raise flag longer than one cycle");
  end_punch_a: assert property ($rose(raise_flag_pulse) && $past(hole_drive)
    |-> tape_advance && !hole_drive)
    else $error("end punch did not swap hole drive for advance");
  punch_idle_a: assert property (!hole_drive |-> punch_data == '0)
    else $error("punch data without hole drive");
  hole_at_speed_a: assert property ($rose(hole_drive) |-> motor_run && !tape_advance)
    else $error("hole drive without motor or during advance");
  buzzer_lamp_a: assert property (alarm_buzzer |-> alarm_lamp)
    else $error("buzzer without lamp");
  error_on_load_a: assert property (data_out_pulse && alarm_lamp |=> alarm_error_flag)
    else $error("error flag not set by load under alarm");
  connect_clr_a: assert property (connect_pulse && !data_out_pulse |=> !alarm_error_flag)
    else $error("connect did not clear error flag");
  raise_c: cover property (raise_flag_pulse);
  hole_c: cover property ($rose(hole_drive));
  buzzer_c: cover property ($fell(alarm_buzzer) && alarm_lamp);
endmodule // tpc_perforator_ctrl_monitor

bind tpc_perforator_ctrl tpc_perforator_ctrl_monitor tpc_mon_inst (.mclk(mclk), .resetn(resetn),
  .data_out_pulse(data_out_pulse), .connect_pulse(connect_pulse), .busy_level(busy_level),
  .raise_flag_pulse(raise_flag_pulse), .alarm_error_flag(alarm_error_flag),
  .motor_run(motor_run), .hole_drive(hole_drive), .punch_data(punch_data),
  .tape_advance(tape_advance), .alarm_lamp(alarm_lamp), .alarm_buzzer(alarm_buzzer),
  .lube_due(lube_due));

// >>> tpc_pkg.sv
// Notes on behaviour
// - end-punch pulse also marks tape advance start.
// - data-out pulse loads buffer in chosen mode.
// - data-out clears buffer-free flag; busy while clear.
// - data-out sets cycle-pending flag.
// - data-out and advance-end retrigger motor delay.
// - sync pulses ignored until motor at speed, except feed-end, which still retriggers the motor delay.
// - start-punch sets hole drive if pending, spun up.
// - hole drive punches buffered data onto tape.
// - end-punch sets tape advance; advance moves tape.
// - end-punch clears hole drive, which clears pending; here pending stays set while another line is queued or being staged.
// - synced end-punch sets buffer-free, dropping busy.
// - synced end-punch raises the flag request.
// - advance-end clears advance; next cycle may start.
// - delay timeout drops motor run, motor coasts.
// - manual advance runs motor; end-punch then advances.
// - alarm sounds buzzer, lamp; error flag next transfer.
// - acknowledge silences buzzer, lamp and flag stay.
// - corrected plus reset clears lamp; flag on connect.
// - tape-low alarms but does not block punching.
// - supply fail or tape end blocks, motor stops; here they leave the motor running until the delay times out.
// - lubrication timer shuts machine off after interval.
// - motor stops five seconds after last transfer.
// - six data bits per line of tape.
package tpc_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DATA_W = 6;
  localparam int unsigned LINE_W = DATA_W + 1;
  localparam int unsigned FIFO_DEPTH = 8;

  // times in their own units
  localparam longint unsigned SPINUP_MS = 1000;
  localparam longint unsigned HOLD_MS = 5000;
  localparam longint unsigned LUBE_LIMIT_MIN = 270;
  localparam longint unsigned LUBE_ADVISE_MIN = 240;

  // derived cycle counts (all exact at this rate)
  localparam longint unsigned SPINUP_CYC = (SPINUP_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned HOLD_CYC = HOLD_MS * CLK_HZ / 1000;
  localparam longint unsigned LUBE_LIMIT_CYC = LUBE_LIMIT_MIN * 60 * CLK_HZ;
  localparam longint unsigned LUBE_ADVISE_CYC = LUBE_ADVISE_MIN * 60 * CLK_HZ;

  localparam int unsigned TIMER_W = 30;
  localparam int unsigned LUBE_W = 42;
  typedef logic [TIMER_W-1:0] tpc_timer_t;
  typedef logic [LUBE_W-1:0] tpc_lube_t;

  localparam logic ALARM_SW_ACK = 1'h1;
  localparam logic RST_BUFFER_FREE = 1'h1;

  typedef enum logic [1:0] {
    TPC_MOTOR_OFF = 2'b00,
    TPC_MOTOR_SPINUP = 2'b01,
    TPC_MOTOR_RATED = 2'b10
  } tpc_motor_t;

endpackage
